// ===== hw/rcl_params.svh
// register offsets, field positions and reset values for the rtc/cmos config block
`ifndef RCL_PARAMS_SVH
`define RCL_PARAMS_SVH
`define RCL_OFF_ACTIVATION 8'h30
`define RCL_OFF_B0_BASE_HI 8'h60
`define RCL_OFF_B0_BASE_LO 8'h61
`define RCL_OFF_B1_BASE_HI 8'h62
`define RCL_OFF_B1_BASE_LO 8'h63
`define RCL_OFF_REGION_LOCK 8'hF0
`define RCL_OFF_IDX_SHADOW 8'hF1
`define RCL_ACT_BANK0_BIT 0
`define RCL_ACT_BANK1_BIT 1
`define RCL_ACT_MASK 8'h03
`define RCL_BASE_HI_MASK 8'h0F
`define RCL_BASE_LO_MASK 8'hFE
`define RCL_LOCK_MASK 8'h0F
`define RCL_RST_ACTIVATION 8'h00
`define RCL_RST_BASE_HI 8'h00
`define RCL_RST_B0_BASE_LO 8'h70
`define RCL_RST_B1_BASE_LO 8'h74
`define RCL_RST_STBY_BASE_LO 8'h00
`define RCL_RST_LOCK 8'h00
`define RCL_LOCKED_READ 8'hFF
`endif

// ===== hw/rcl_pkg.sv
// types shared by the rtc/cmos config block
package rcl_pkg;
   // which reset source is acting this cycle
   typedef enum logic [1:0] {
      RCL_RST_NONE,
      RCL_RST_SOFT,
      RCL_RST_MAIN,
      RCL_RST_STBY
   } rcl_rst_kind_t;
   // cmos access decoding
   typedef enum logic [1:0] {
      RCL_HIT_NONE,
      RCL_HIT_BANK0,
      RCL_HIT_BANK1
   } rcl_hit_t;
endpackage

// ===== hw/rcl_cmos_if.sv
// signals between the cmos access gate and the region lock keeper
`timescale 1ns/10ps
interface rcl_cmos_if;
   logic [3:0] lock_bits;
   logic main_power_ok;
   logic [6:0] bank1_offset;
   logic blocked;
   modport gate (input lock_bits, input main_power_ok, input bank1_offset, output blocked);
   modport keeper (output lock_bits, output main_power_ok, output bank1_offset, input blocked);
endinterface

// ===== hw/rcl_lock_gate.sv
// decides whether a bank 1 cmos access falls in a locked region
`timescale 1ns/10ps
module rcl_lock_gate (
   rcl_cmos_if.gate lk
);
   // region index is offset bits 6:5, four 32-byte blocks
   always_comb begin
      lk.blocked = lk.main_power_ok & lk.lock_bits[lk.bank1_offset[6:5]]; // [R5] [R8]
   end
endmodule // rcl_lock_gate

// ===== hw/rcl_addr_match.sv
// matches a host i/o address against one bank's programmable base
`timescale 1ns/10ps
module rcl_addr_match (
   input wire logic enable,
   input wire logic [7:0] base_hi,
   input wire logic [7:0] base_lo,
   input wire logic [15:0] io_addr,
   output logic hit,
   output logic data_port
);
   // base is even aligned: index at base, data at base+1; upper address bits must be zero
   always_comb begin
      hit = enable && (io_addr[15:12] == 4'h0) && (io_addr[11:8] == base_hi[3:0])
         && (io_addr[7:1] == base_lo[7:1]); // [R2] [R3]
      data_port = io_addr[0];
   end
endmodule // rcl_addr_match

// ===== hw/rcl_config_regs.sv
// rtc/cmos configuration registers, base decode and bank 1 region lock
`timescale 1ns/10ps
`include "rcl_params.svh"

// Behaviour
// [R1] activation bit 0 enables clock and bank 0 decode, bit 1 enables bank 1 decode, bits 7:2 reserved.
// [R2] each bank's high base byte gives address bits 11:8 from its low nibble, upper nibble reads zero.
// [R3] each bank's low base byte gives address bits 7:1, bit 0 reads zero so bases are even.
// [R4] main, bus or soft reset loads low bases 0x70 and 0x74; standby power-on reset loads zero.
// [R5] lock bits 0 to 3 each lock one 32-byte region of bank 1, bits 7:4 reserved as zero.
// [R6] a set lock bit stays set and writing zero to it does nothing.
// [R7] lock bits clear on main power-on reset, loss of main power and bus reset.
// [R8] while main power is present, host access to a locked region is refused.
// [R9] the shadow register returns the bank 0 index register and ignores writes.
// [R10] soft reset keeps lock bits, locked writes are dropped and locked reads return all ones.
module rcl_config_regs #(
   parameter int INDEX_W = 7,
   parameter int LOCK_REGIONS = 4
) (
   core_clk,
   sys_rst,
   main_por,
   bus_rst,
   soft_rst,
   main_power_ok,
   cfg_addr,
   cfg_wdata,
   cfg_wr,
   cfg_rd,
   cfg_rdata,
   io_addr,
   io_wdata,
   io_wr,
   io_rd,
   io_rdata,
   io_hit,
   rtc_enable,
   cmos_wr,
   cmos_rd,
   cmos_bank,
   cmos_addr,
   cmos_wdata,
   cmos_rdata
);
   input wire logic core_clk;
   input wire logic sys_rst; // standby power-on reset, async
   input wire logic main_por;
   input wire logic bus_rst;
   input wire logic soft_rst;
   input wire logic main_power_ok;
   input wire logic [7:0] cfg_addr;
   input wire logic [7:0] cfg_wdata;
   input wire logic cfg_wr;
   input wire logic cfg_rd;
   output logic [7:0] cfg_rdata;
   input wire logic [15:0] io_addr;
   input wire logic [7:0] io_wdata;
   input wire logic io_wr;
   input wire logic io_rd;
   output logic [7:0] io_rdata;
   output logic io_hit;
   output logic rtc_enable;
   output logic cmos_wr;
   output logic cmos_rd;
   output logic cmos_bank;
   output logic [6:0] cmos_addr;
   output logic [7:0] cmos_wdata;
   input wire logic [7:0] cmos_rdata;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] act_reg, act_next;
   logic [7:0] b0_hi_reg, b0_hi_next;
   logic [7:0] b0_lo_reg, b0_lo_next;
   logic [7:0] b1_hi_reg, b1_hi_next;
   logic [7:0] b1_lo_reg, b1_lo_next;
   logic [3:0] lock_reg, lock_next;
   logic [6:0] idx0_reg, idx0_next;
   logic [6:0] idx1_reg, idx1_next;
   logic [7:0] cfg_rdata_reg, cfg_rdata_next;
   logic [7:0] io_rdata_reg, io_rdata_next;
   logic io_hit_reg, io_hit_next;
   logic pend_rd_reg, pend_rd_next;
   logic pend_lock_reg, pend_lock_next;
   rcl_pkg::rcl_rst_kind_t rst_kind;
   logic hit0, hit1, dp0, dp1;

   // carrier between the lock state kept here and the region gate
   rcl_cmos_if lk_if ();

   // ----------------------------------------
   // elaboration checks and helpers
   // ----------------------------------------
   // index port, lock gate and carrier are sized for a 7-bit index and four regions
   if (INDEX_W != 7 || LOCK_REGIONS != 4) begin : g_bad_params
      $error("rcl_config_regs serves only INDEX_W 7 and LOCK_REGIONS 4");
   end

   // index-port access of one bank, shared by the index write and the index readback
   function automatic logic index_port(input logic hit, input logic dport);
      return hit & ~dport;
   endfunction

   // data-port access that may reach the cmos array; bank 0 wins and is never gated
   function automatic logic data_pass(input logic h0, input logic d0, input logic h1, input logic d1,
      input logic blk);
      return (h0 & d0) | (~h0 & h1 & d1 & ~blk);
   endfunction

   // ----------------------------------------
   // reset source priority
   // ----------------------------------------
   // main power-on dominates bus reset, which dominates soft reset
   always_comb begin
      if (main_por) begin
         rst_kind = rcl_pkg::RCL_RST_MAIN;
      end else if (bus_rst) begin
         rst_kind = rcl_pkg::RCL_RST_MAIN;
      end else if (soft_rst) begin
         rst_kind = rcl_pkg::RCL_RST_SOFT;
      end else begin
         rst_kind = rcl_pkg::RCL_RST_NONE;
      end
   end

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   rcl_addr_match u_match0 (
      .enable(act_reg[`RCL_ACT_BANK0_BIT]), // [R1]
      .base_hi(b0_hi_reg),
      .base_lo(b0_lo_reg),
      .io_addr(io_addr),
      .hit(hit0),
      .data_port(dp0)
   );

   rcl_addr_match u_match1 (
      .enable(act_reg[`RCL_ACT_BANK1_BIT]), // [R1]
      .base_hi(b1_hi_reg),
      .base_lo(b1_lo_reg),
      .io_addr(io_addr),
      .hit(hit1),
      .data_port(dp1)
   );

   // lock gate looks at the bank 1 index being used for a data access
   // only bank 1 is gated; bank 0 has no lock bits at all
   assign lk_if.lock_bits = lock_reg;
   assign lk_if.main_power_ok = main_power_ok;
   assign lk_if.bank1_offset = idx1_reg;

   rcl_lock_gate u_gate (
      .lk(lk_if.gate)
   );

   // ----------------------------------------
   // cmos side strobes
   // ----------------------------------------
   // bank 0 has priority if software overlaps both bases
   always_comb begin
      cmos_bank = ~hit0 & hit1;
      cmos_addr = hit0 ? idx0_reg : idx1_reg;
      cmos_wdata = io_wdata;
      cmos_wr = io_wr & data_pass(hit0, dp0, hit1, dp1, lk_if.blocked); // [R8] [R10]
      cmos_rd = io_rd & data_pass(hit0, dp0, hit1, dp1, lk_if.blocked); // [R8]
   end

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      act_next = act_reg;
      b0_hi_next = b0_hi_reg;
      b0_lo_next = b0_lo_reg;
      b1_hi_next = b1_hi_reg;
      b1_lo_next = b1_lo_reg;
      lock_next = lock_reg;
      idx0_next = idx0_reg;
      idx1_next = idx1_reg;
      cfg_rdata_next = cfg_rdata_reg;
      io_rdata_next = io_rdata_reg;
      io_hit_next = 1'b0;
      pend_rd_next = 1'b0;
      pend_lock_next = 1'b0;
      // register writes
      if (cfg_wr) begin
         case (cfg_addr)
            `RCL_OFF_ACTIVATION: act_next = cfg_wdata & `RCL_ACT_MASK; // [R1]
            `RCL_OFF_B0_BASE_HI: b0_hi_next = cfg_wdata & `RCL_BASE_HI_MASK; // [R2]
            `RCL_OFF_B0_BASE_LO: b0_lo_next = cfg_wdata & `RCL_BASE_LO_MASK; // [R3]
            `RCL_OFF_B1_BASE_HI: b1_hi_next = cfg_wdata & `RCL_BASE_HI_MASK; // [R2]
            `RCL_OFF_B1_BASE_LO: b1_lo_next = cfg_wdata & `RCL_BASE_LO_MASK; // [R3]
            `RCL_OFF_REGION_LOCK: lock_next = lock_reg | cfg_wdata[3:0]; // [R5] [R6]
            default: begin
               // shadow and unmapped offsets ignore writes
            end
         endcase
      end
      // register reads, data in the following cycle
      if (cfg_rd) begin
         case (cfg_addr)
            `RCL_OFF_ACTIVATION: cfg_rdata_next = act_reg;
            `RCL_OFF_B0_BASE_HI: cfg_rdata_next = b0_hi_reg;
            `RCL_OFF_B0_BASE_LO: cfg_rdata_next = b0_lo_reg;
            `RCL_OFF_B1_BASE_HI: cfg_rdata_next = b1_hi_reg;
            `RCL_OFF_B1_BASE_LO: cfg_rdata_next = b1_lo_reg;
            `RCL_OFF_REGION_LOCK: cfg_rdata_next = {4'h0, lock_reg};
            `RCL_OFF_IDX_SHADOW: cfg_rdata_next = {1'b0, idx0_reg}; // [R9]
            default: cfg_rdata_next = 8'h00;
         endcase
      end
      // host i/o: index ports load the index, data ports pass to cmos
      if (index_port(hit0, dp0) && io_wr) begin
         idx0_next = io_wdata[6:0];
      end else if (!hit0 && index_port(hit1, dp1) && io_wr) begin
         idx1_next = io_wdata[6:0];
      end
      if (io_rd && (hit0 || hit1)) begin
         io_hit_next = 1'b1;
         if (index_port(hit0, dp0)) begin
            io_rdata_next = {1'b0, idx0_reg};
         end else if (!hit0 && index_port(hit1, dp1)) begin
            io_rdata_next = {1'b0, idx1_reg};
         end else begin
            pend_rd_next = 1'b1;
            pend_lock_next = !hit0 && lk_if.blocked;
         end
      end
      // cmos data arrives the cycle after the strobe; locked reads give all ones
      if (pend_rd_reg) begin
         io_rdata_next = pend_lock_reg ? `RCL_LOCKED_READ : cmos_rdata; // [R10]
      end
      // soft reset restores configuration but keeps lock bits
      if (rst_kind == rcl_pkg::RCL_RST_SOFT) begin
         act_next = `RCL_RST_ACTIVATION;
         b0_hi_next = `RCL_RST_BASE_HI;
         b0_lo_next = `RCL_RST_B0_BASE_LO; // [R4]
         b1_hi_next = `RCL_RST_BASE_HI;
         b1_lo_next = `RCL_RST_B1_BASE_LO; // [R4]
         lock_next = lock_reg; // [R10]
      end else if (rst_kind == rcl_pkg::RCL_RST_MAIN) begin
         // main power-on and bus reset also drop the locks, beating a same-cycle set
         act_next = `RCL_RST_ACTIVATION;
         b0_hi_next = `RCL_RST_BASE_HI;
         b0_lo_next = `RCL_RST_B0_BASE_LO; // [R4]
         b1_hi_next = `RCL_RST_BASE_HI;
         b1_lo_next = `RCL_RST_B1_BASE_LO; // [R4]
         lock_next = 4'(`RCL_RST_LOCK); // [R7]
      end
      // losing main power drops every lock
      if (!main_power_ok) begin
         lock_next = 4'(`RCL_RST_LOCK); // [R7]
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // sys_rst is the standby power-on reset: low bases come up zero
   // indexes and locks clear with it, so nothing stale survives a standby cycle
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         act_reg <= `RCL_RST_ACTIVATION;
         b0_hi_reg <= `RCL_RST_BASE_HI;
         b0_lo_reg <= `RCL_RST_STBY_BASE_LO; // [R4]
         b1_hi_reg <= `RCL_RST_BASE_HI;
         b1_lo_reg <= `RCL_RST_STBY_BASE_LO; // [R4]
         lock_reg <= 4'h0;
         idx0_reg <= 7'h00;
         idx1_reg <= 7'h00;
         cfg_rdata_reg <= 8'h00;
         io_rdata_reg <= 8'h00;
         io_hit_reg <= 1'b0;
         pend_rd_reg <= 1'b0;
         pend_lock_reg <= 1'b0;
      end else begin
         act_reg <= act_next;
         b0_hi_reg <= b0_hi_next;
         b0_lo_reg <= b0_lo_next;
         b1_hi_reg <= b1_hi_next;
         b1_lo_reg <= b1_lo_next;
         lock_reg <= lock_next;
         idx0_reg <= idx0_next;
         idx1_reg <= idx1_next;
         cfg_rdata_reg <= cfg_rdata_next;
         io_rdata_reg <= io_rdata_next;
         io_hit_reg <= io_hit_next;
         pend_rd_reg <= pend_rd_next;
         pend_lock_reg <= pend_lock_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // data outputs straight from flops, so no decode glitch reaches the host
   assign cfg_rdata = cfg_rdata_reg;
   assign io_rdata = io_rdata_reg;
   assign io_hit = io_hit_reg;
   assign rtc_enable = act_reg[`RCL_ACT_BANK0_BIT]; // [R1]
endmodule // rcl_config_regs

// ===== sim/rcl_cfg_assertions.sv
// port-level checks for the rtc/cmos config block
`timescale 1ns/10ps
module rcl_cfg_assertions (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic main_por,
   input wire logic bus_rst,
   input wire logic main_power_ok,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_rdata,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   input wire logic io_hit,
   input wire logic rtc_enable,
   input wire logic cmos_wr,
   input wire logic cmos_rd,
   input wire logic cmos_bank,
   input wire logic [6:0] cmos_addr,
   input wire logic [7:0] cmos_wdata
);
   logic rd_q;
   logic [7:0] addr_q;
   logic [3:0] seen_reg;
   logic seen_v;
   logic clr;
   logic clr_q;
   assign clr = main_por | bus_rst | ~main_power_ok;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // helper: last lock value seen on readback
   // ----------------------------------------
   // only a subset of the real lock bits, so safe as a floor
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_q <= 1'b0;
         addr_q <= 8'h00;
         seen_reg <= 4'h0;
         seen_v <= 1'b0;
         clr_q <= 1'b0;
      end else begin
         rd_q <= cfg_rd;
         addr_q <= cfg_addr;
         clr_q <= clr;
         // a readback taken in a clearing cycle shows the old locks, so skip it
         if (clr) begin
            seen_v <= 1'b0;
         end else if (rd_q && addr_q == 8'hF0 && !clr_q) begin
            seen_reg <= cfg_rdata[3:0];
            seen_v <= 1'b1;
         end
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   act_rsvd_a: assert property (cfg_rd && cfg_addr == 8'h30 |=> cfg_rdata[7:2] == 6'h00)
      else $error("activation reserved bits nonzero");
   base_hi_a: assert property (cfg_rd && (cfg_addr == 8'h60 || cfg_addr == 8'h62) |=> cfg_rdata[7:4] == 4'h0)
      else $error("base high upper nibble nonzero");
   base_lo_a: assert property (cfg_rd && (cfg_addr == 8'h61 || cfg_addr == 8'h63) |=> !cfg_rdata[0])
      else $error("base low bit 0 set");
   lo_reset_a: assert property (main_por ##1 !cfg_wr ##1 (cfg_rd && cfg_addr == 8'h61) |=> cfg_rdata == 8'h70)
      else $error("bank 0 low base not reloaded");
   lock_rsvd_a: assert property (cfg_rd && cfg_addr == 8'hF0 |=> cfg_rdata[7:4] == 4'h0)
      else $error("lock reserved bits nonzero");
   lock_sticky_a: assert property (rd_q && addr_q == 8'hF0 && seen_v |-> (cfg_rdata[3:0] & seen_reg) == seen_reg)
      else $error("lock bit dropped");
   lock_clr_a: assert property (clr ##1 !cfg_wr ##1 (cfg_rd && cfg_addr == 8'hF0) |=> cfg_rdata[3:0] == 4'h0)
      else $error("lock bits survived clear");
   locked_refuse_a: assert property ((cmos_rd || cmos_wr) && cmos_bank && main_power_ok && seen_v
      |-> !seen_reg[cmos_addr[6:5]])
      else $error("strobe reached locked region");
   wr_pass_a: assert property (cmos_wr |-> io_wr && cmos_wdata == io_wdata)
      else $error("cmos write without host write");
   bank0_en_a: assert property ((cmos_rd || cmos_wr) && !cmos_bank |-> rtc_enable)
      else $error("bank 0 access while inactive");
   hit_cause_a: assert property (io_hit |-> $past(io_rd))
      else $error("hit without host read");
   lock_set_c: cover property (rd_q && addr_q == 8'hF0 && cfg_rdata == 8'h0F);
   bank1_rd_c: cover property (cmos_rd && cmos_bank);
   hit_c: cover property (io_hit);
   bank0_wr_c: cover property (cmos_wr && !cmos_bank);
endmodule // rcl_cfg_assertions

// ===== sim/rcl_config_regs_tb.sv
// self-checking bench for the rtc/cmos config block
`timescale 1ns/10ps
module rcl_config_regs_tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic main_por = 1'b0, bus_rst = 1'b0, soft_rst = 1'b0, main_power_ok = 1'b1;
   logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, io_wdata = 8'h00, io_rdata;
   logic cfg_wr = 1'b0, cfg_rd = 1'b0, io_wr = 1'b0, io_rd = 1'b0, io_hit, rtc_enable;
   logic [15:0] io_addr = 16'h0000;
   logic cmos_wr, cmos_rd, cmos_bank;
   logic [6:0] cmos_addr;
   logic [7:0] cmos_wdata, cmos_rdata = 8'h00;
   logic [7:0] ra [5] = '{8'h30, 8'h60, 8'h61, 8'h62, 8'h63};
   logic [7:0] rm [5] = '{8'h03, 8'h0F, 8'hFE, 8'h0F, 8'hFE};
   int miscompares = 0, n_tests = 0;
   rcl_config_regs dut_u (.core_clk, .sys_rst, .main_por, .bus_rst, .soft_rst, .main_power_ok, .cfg_addr,
      .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata, .io_hit,
      .rtc_enable, .cmos_wr, .cmos_rd, .cmos_bank, .cmos_addr, .cmos_wdata, .cmos_rdata);
   // 250 MHz clock
   initial forever #2 core_clk = ~core_clk;
   // cmos array stand-in: a pattern of bank and index, ready a cycle after the strobe
   always @(posedge core_clk) cmos_rdata <= {cmos_bank, cmos_addr} ^ 8'h5A;
   function automatic logic [7:0] mem(input logic b, input logic [6:0] i);
      return {b, i} ^ 8'h5A;
   endfunction
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask
   task automatic cw(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_wr <= 1'b1;
      @(posedge core_clk);
      cfg_wr <= 1'b0;
   endtask
   task automatic cr(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      cfg_addr <= a;
      cfg_rd <= 1'b1;
      @(posedge core_clk);
      cfg_rd <= 1'b0;
      #1 chk(cfg_rdata, e);
   endtask
   task automatic iw(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge core_clk);
      io_wr <= 1'b0;
   endtask
   // data reads leave two idle cycles before the next request
   task automatic ir(input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge core_clk);
      io_rd <= 1'b0;
      #1 chk({7'h00, io_hit}, 8'h01);
      @(posedge core_clk);
      #1 chk(io_rdata, e);
   endtask
   // one-cycle pulse of {main, bus, soft} reset
   task automatic pulse(input logic [2:0] k);
      @(posedge core_clk);
      {main_por, bus_rst, soft_rst} <= k;
      @(posedge core_clk);
      {main_por, bus_rst, soft_rst} <= 3'b000;
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      cr(8'h61, 8'h00);
      cr(8'h63, 8'h00);
      pulse(3'b100);
      cr(8'h61, 8'h70);
      cr(8'h63, 8'h74);
      cr(8'h30, 8'h00);
      for (int i = 0; i < 5; i++) begin
         cw(ra[i], 8'hFF);
         cr(ra[i], rm[i]);
      end
      chk({7'h00, rtc_enable}, 8'h01);
      cw(8'h60, 8'h00);
      cw(8'h61, 8'h70);
      cw(8'h62, 8'h00);
      cw(8'h63, 8'h74);
      cw(8'h31, 8'hFF);
      cr(8'h31, 8'h00);
      iw(16'h0070, 8'h2A);
      cr(8'hF1, 8'h2A);
      cw(8'hF1, 8'h55);
      cr(8'hF1, 8'h2A);
      ir(16'h0071, mem(1'b0, 7'h2A));
      iw(16'h0071, 8'h3C);
      iw(16'h0074, 8'h05);
      ir(16'h0075, mem(1'b1, 7'h05));
      cw(8'hF0, 8'hF1);
      cr(8'hF0, 8'h01);
      // each region: top byte locked, first byte of the next still open
      for (int i = 0; i < 4; i++) begin
         cw(8'hF0, 8'h01 << i);
         cr(8'hF0, (8'h02 << i) - 8'h01);
         iw(16'h0074, 8'(i * 32 + 31));
         ir(16'h0075, 8'hFF);
         iw(16'h0075, 8'h99);
         if (i < 3) begin
            iw(16'h0074, 8'((i + 1) * 32));
            ir(16'h0075, mem(1'b1, 7'((i + 1) * 32)));
         end
      end
      cw(8'hF0, 8'h00);
      cr(8'hF0, 8'h0F);
      iw(16'h0070, 8'h11);
      ir(16'h0071, mem(1'b0, 7'h11));
      pulse(3'b001);
      cr(8'hF0, 8'h0F);
      cr(8'h30, 8'h00);
      chk({7'h00, rtc_enable}, 8'h00);
      // banks now inactive: a read at the old data port must not hit
      @(posedge core_clk);
      io_addr <= 16'h0071;
      io_rd <= 1'b1;
      @(posedge core_clk);
      io_rd <= 1'b0;
      #1 chk({7'h00, io_hit}, 8'h00);
      @(posedge core_clk);
      main_power_ok <= 1'b0;
      @(posedge core_clk);
      main_power_ok <= 1'b1;
      cr(8'hF0, 8'h00);
      cw(8'hF0, 8'h04);
      cr(8'hF0, 8'h04);
      pulse(3'b010);
      cr(8'hF0, 8'h00);
      cw(8'hF0, 8'h08);
      cr(8'hF0, 8'h08);
      pulse(3'b100);
      cr(8'hF0, 8'h00);
      results();
   end
   // watchdog: the sequence needs well under 1000 cycles
   initial begin
      #20000;
      miscompares++;
      results();
   end
endmodule // rcl_config_regs_tb

bind rcl_config_regs rcl_cfg_assertions chk_u (.core_clk, .sys_rst, .main_por, .bus_rst, .main_power_ok,
   .cfg_addr, .cfg_wr, .cfg_rd, .cfg_rdata, .io_rd, .io_wr, .io_wdata, .io_hit, .rtc_enable, .cmos_wr,
   .cmos_rd, .cmos_bank, .cmos_addr, .cmos_wdata);
